// ===== uamc_alt_mode.v
// ulpi alternate mode control: serial, carkit, headset modes behind an ahb-lite slave
//
// Summary of operation
// [RULE1] serial mode: link drives enable, data, single-zero
// [RULE2] serial mode: plus, minus, differential levels out
// [RULE3] serial bit3 unmasked interrupt, bit7 low
// [RULE4] carkit stops clock unless keep bit set
// [RULE5] latch sources before dir, flag differences
// [RULE6] no line state given in carkit mode
// [RULE7] stp exits: drop dir, await stp low
// [RULE8] hardware reset pulse returns to synchronous mode
// [RULE9] link sets route bits before carkit bit
// [RULE10] uart mode bus mapping and route enables
// [RULE11] uart entry: regulator setting and pull-ups
// [RULE12] uart edge rate follows speed select
// [RULE13] audio switches follow write at once
// [RULE14] id ground fall reported per mode
// [RULE15] start bit begins measurement, clears when done
// [RULE16] conversion done sends alternate-interrupt command
// [RULE17] result field holds measured code
// [RULE18] headset register write enters headset mode
// [RULE19] headset bit0 session valid, bit3 low
// [RULE20] headset bit1 vbus valid when enabled
// [RULE21] headset bit4 id low state, bit5 open
// [RULE22] headset inputs drive id ground, pull-ups
// [RULE23] dir and clock stop five cycles later
// [RULE24] serial select bit clears on exit
// [RULE25] carkit and headset selects clear on exit
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "uamc_consts.vh"
module uamc_alt_mode (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire hw_reset_n,
    input wire link_stp,
    input wire [7:0] link_data_in,
    output reg [7:0] link_data_out,
    output reg [7:0] link_data_oe,
    output reg link_dir,
    output reg clk_run,
    output reg rxcmd_valid,
    output reg [7:0] rxcmd_data,
    input wire serial_rx_plus_line,
    input wire serial_rx_minus_line,
    input wire serial_rx_diff,
    input wire [7:0] irq_src,
    input wire id_low_comparator,
    input wire session_valid_cmp,
    input wire vbus_valid_cmp,
    input wire id_pin_open_state,
    input wire id_meas_done,
    input wire [4:0] id_meas_code,
    output reg tx_enable_out,
    output reg tx_diff_out,
    output reg serial_tx_single_zero,
    output reg uart_dm_drive,
    output reg uart_dm_drive_en,
    output reg uart_pullup_en,
    output reg [1:0] regulator_level,
    output reg [1:0] edge_rate_sel,
    output reg left_audio_switch_en,
    output reg right_audio_switch_en,
    output reg id_pin_ground_drive,
    output reg id_weak_pullup_en,
    output reg id_strong_pullup_en,
    output reg id_meas_start_pulse
);
    // mode states
    localparam [1:0] ST_SYNC = 2'd0;
    localparam [1:0] ST_ENTER = 2'd1;
    localparam [1:0] ST_ALT = 2'd2;
    localparam [1:0] ST_EXIT = 2'd3;
    // inputs brought through synchronisers
    localparam integer NSYNC = 25;

    // synchroniser stages
    reg [NSYNC-1:0] sync1_r;
    reg [NSYNC-1:0] sync2_r;
    wire [NSYNC-1:0] async_in;
    assign async_in = {id_pin_open_state, vbus_valid_cmp, session_valid_cmp, id_low_comparator,
                       irq_src, serial_rx_diff, serial_rx_minus_line, serial_rx_plus_line,
                       link_data_in, link_stp, hw_reset_n};
    // synchronised views
    wire hwrst_s = sync2_r[0];
    wire stp_s = sync2_r[1];
    wire [7:0] din_s = sync2_r[9:2];
    wire rxp_s = sync2_r[10];
    wire rxm_s = sync2_r[11];
    wire rxd_s = sync2_r[12];
    wire [7:0] irq_s = sync2_r[20:13];
    wire idlow_s = sync2_r[21];
    wire sess_s = sync2_r[22];
    wire vbus_s = sync2_r[23];
    wire idopen_s = sync2_r[24];

    // registers
    reg [7:0] func_r;
    reg [7:0] ifc_r;
    reg [7:0] carkit_r;
    reg [7:0] ckirq_r;
    reg [7:0] headset_r;
    reg [7:0] rid_r;
    reg [7:0] pwr_r;
    reg [1:0] state_r;
    reg [2:0] cnt_r;
    reg [7:0] irq_latch_r;
    reg idlow_d_r;
    // pending ahb data phase
    reg wr_pend_r;
    reg [5:0] wr_idx_r;

    // per-bit two flip-flop synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= async_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // write / set / clear update by offset from the base index
    function [7:0] upd;
        input [7:0] old;
        input [7:0] wd;
        input [5:0] op;
        begin
            if (op == 6'd0) begin
                upd = wd;
            end else if (op == 6'd1) begin
                upd = old | wd;
            end else begin
                upd = old & ~wd;
            end
        end
    endfunction

    // address phase decode
    wire take = hsel & htrans[1] & hready;
    wire [5:0] a_idx = haddr[7:2];
    wire [5:0] w_func = wr_idx_r - `UAMC_IDX_FUNC;
    wire [5:0] w_ifc = wr_idx_r - `UAMC_IDX_IFC;
    wire [5:0] w_ck = wr_idx_r - `UAMC_IDX_CARKIT;
    wire [5:0] w_ckirq = wr_idx_r - `UAMC_IDX_CKIRQ;
    wire [5:0] w_rid = wr_idx_r - `UAMC_IDX_RID;
    wire [5:0] w_pwr = wr_idx_r - `UAMC_IDX_PWR;
    wire [7:0] wd = hwdata[7:0];
    wire [7:0] rid_upd = upd(rid_r, wd, w_rid); // value after write
    // modes selected
    wire alt_sel = ifc_r[`UAMC_IFC_SERIAL] | ifc_r[`UAMC_IFC_CARKIT] | headset_r[`UAMC_HS_EN];
    wire in_alt = (state_r == ST_ALT);
    // unmasked interrupt: live level differs from entry latch
    wire alt_irq = |((irq_s ^ irq_latch_r) & ckirq_r); // [RULE5]
    // id ground comparator falling edge
    wire id_fall = idlow_d_r & ~idlow_s & hwrst_s;

    // read mux
    reg [7:0] rd_val;
    always @* begin
        if (a_idx >= `UAMC_IDX_FUNC && a_idx <= `UAMC_IDX_FUNC + 6'd2) begin
            rd_val = func_r;
        end else if (a_idx >= `UAMC_IDX_IFC && a_idx <= `UAMC_IDX_IFC + 6'd2) begin
            rd_val = ifc_r;
        end else if (a_idx >= `UAMC_IDX_CARKIT && a_idx <= `UAMC_IDX_CARKIT + 6'd2) begin
            rd_val = carkit_r;
        end else if (a_idx >= `UAMC_IDX_CKIRQ && a_idx <= `UAMC_IDX_CKIRQ + 6'd2) begin
            rd_val = ckirq_r;
        end else if (a_idx == `UAMC_IDX_HEADSET) begin
            rd_val = headset_r;
        end else if (a_idx >= `UAMC_IDX_RID && a_idx <= `UAMC_IDX_RID + 6'd2) begin
            rd_val = rid_r; // [RULE15] [RULE17]
        end else if (a_idx >= `UAMC_IDX_PWR && a_idx <= `UAMC_IDX_PWR + 6'd2) begin
            rd_val = pwr_r;
        end else if (a_idx == `UAMC_IDX_STATUS) begin
            rd_val = {irq_latch_r[3:0], alt_irq, idlow_s, state_r};
        end else begin
            rd_val = 8'h00; // unmapped reads zero
        end
    end

    // ahb slave handshake and read data; always zero wait, okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= 1'b0;
            wr_idx_r <= 6'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= take & hwrite;
            if (take) begin
                wr_idx_r <= a_idx;
            end
            if (take & ~hwrite) begin
                hrdata <= {24'h00_0000, rd_val};
            end
        end
    end

    // register file, mode machine and auto-clears
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_r <= `UAMC_RST_FUNC;
            ifc_r <= 8'h00;
            carkit_r <= 8'h00;
            ckirq_r <= 8'h00;
            headset_r <= 8'h00;
            rid_r <= 8'h00;
            pwr_r <= `UAMC_RST_PWR;
            state_r <= ST_SYNC;
            cnt_r <= 3'd0;
            irq_latch_r <= 8'h00;
            idlow_d_r <= 1'b1;
        end else if (!hwrst_s) begin
            // held in reset by the pin
            ifc_r <= 8'h00; // [RULE8]
            headset_r <= 8'h00;
            state_r <= ST_SYNC;
            cnt_r <= 3'd0;
        end else begin
            idlow_d_r <= idlow_s;
            // writes taken in synchronous mode only
            if (wr_pend_r && state_r == ST_SYNC) begin
                if (w_func <= 6'd2) begin
                    func_r <= upd(func_r, wd, w_func) & 8'h7f;
                end
                if (w_ifc <= 6'd2) begin
                    ifc_r <= upd(ifc_r, wd, w_ifc); // [RULE24]
                end
                if (w_ck <= 6'd2) begin
                    carkit_r <= upd(carkit_r, wd, w_ck); // [RULE13]
                end
                if (w_ckirq <= 6'd2) begin
                    ckirq_r <= upd(ckirq_r, wd, w_ckirq);
                end
                if (wr_idx_r == `UAMC_IDX_HEADSET) begin
                    headset_r <= wd; // [RULE18]
                end
                if (w_rid <= 6'd2) begin
                    // result field stays read-only
                    rid_r[2:0] <= rid_upd[2:0] & 3'h3; // [RULE15]
                end
                if (w_pwr <= 6'd2) begin
                    pwr_r <= upd(pwr_r, wd, w_pwr);
                end
            end
            // conversion finished: clear start, store code; done wins over a write
            if (id_meas_done && rid_r[`UAMC_RID_START]) begin
                rid_r[`UAMC_RID_START] <= 1'b0; // [RULE15]
                rid_r[7:`UAMC_RID_RES_LSB] <= id_meas_code; // [RULE17]
            end
            case (state_r)
                ST_SYNC: begin
                    cnt_r <= 3'd0;
                    if (alt_sel) begin
                        state_r <= ST_ENTER;
                    end
                end
                ST_ENTER: begin
                    cnt_r <= cnt_r + 3'd1;
                    // sample sources just before dir rises
                    irq_latch_r <= irq_s; // [RULE5]
                    if (cnt_r == `UAMC_ENTRY_CYCLES - 3'd1) begin
                        state_r <= ST_ALT; // [RULE23]
                    end
                end
                ST_ALT: begin
                    if (stp_s) begin
                        state_r <= ST_EXIT; // [RULE7]
                    end
                end
                default: begin
                    if (!stp_s) begin
                        state_r <= ST_SYNC; // [RULE7]
                        ifc_r[`UAMC_IFC_SERIAL] <= 1'b0; // [RULE24]
                        ifc_r[`UAMC_IFC_CARKIT] <= 1'b0; // [RULE25]
                        headset_r[`UAMC_HS_EN] <= 1'b0; // [RULE25]
                    end
                end
            endcase
        end
    end

    // link pins, receive commands and analog controls
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_data_out <= 8'h00;
            link_data_oe <= 8'h00;
            link_dir <= 1'b0;
            clk_run <= 1'b1;
            rxcmd_valid <= 1'b0;
            rxcmd_data <= 8'h00;
            tx_enable_out <= 1'b0;
            tx_diff_out <= 1'b0;
            serial_tx_single_zero <= 1'b0;
            uart_dm_drive <= 1'b0;
            uart_dm_drive_en <= 1'b0;
            uart_pullup_en <= 1'b0;
            regulator_level <= 2'b00;
            edge_rate_sel <= 2'b01;
            left_audio_switch_en <= 1'b0;
            right_audio_switch_en <= 1'b0;
            id_pin_ground_drive <= 1'b0;
            id_weak_pullup_en <= 1'b0;
            id_strong_pullup_en <= 1'b0;
            id_meas_start_pulse <= 1'b0;
        end else begin
            // defaults: synchronous mode, link owns the bus
            link_data_out <= 8'h00;
            link_data_oe <= 8'h00;
            link_dir <= in_alt;
            clk_run <= ~in_alt | ifc_r[`UAMC_IFC_KEEPCLK]; // [RULE4] [RULE23]
            rxcmd_valid <= 1'b0;
            rxcmd_data <= 8'h00;
            tx_enable_out <= 1'b0;
            tx_diff_out <= 1'b0;
            serial_tx_single_zero <= 1'b0;
            uart_dm_drive <= 1'b0;
            uart_dm_drive_en <= 1'b0;
            uart_pullup_en <= 1'b0;
            regulator_level <= 2'b00;
            edge_rate_sel <= func_r[1:0]; // [RULE12]
            // audio switches follow the register at once
            left_audio_switch_en <= carkit_r[`UAMC_CK_LEFT]; // [RULE13]
            right_audio_switch_en <= carkit_r[`UAMC_CK_RIGHT]; // [RULE13]
            id_pin_ground_drive <= 1'b0;
            id_weak_pullup_en <= 1'b0;
            id_strong_pullup_en <= 1'b0;
            // one pulse when start is written
            id_meas_start_pulse <= wr_pend_r && (w_rid <= 6'd2) && state_r == ST_SYNC
                                   && rid_upd[0] && !rid_r[0]; // [RULE15]
            if (in_alt && ifc_r[`UAMC_IFC_SERIAL]) begin
                // six pin serial: bits 3..6 driven, 7 low
                link_data_oe <= 8'hf8;
                link_data_out <= {1'b0, rxd_s, rxm_s, rxp_s, alt_irq | id_fall, 3'b000}; // [RULE2] [RULE3] [RULE14]
                tx_enable_out <= din_s[0]; // [RULE1]
                tx_diff_out <= din_s[1]; // [RULE1]
                serial_tx_single_zero <= din_s[2]; // [RULE1]
            end else if (in_alt && ifc_r[`UAMC_IFC_CARKIT]) begin
                // carkit: no line state; bits 1,3 only, rest low
                link_data_oe <= 8'hfe; // [RULE6]
                link_data_out <= {4'h0, alt_irq | id_fall, 1'b0,
                                  rxp_s & carkit_r[`UAMC_CK_IN_ROUTE], 1'b0}; // [RULE10] [RULE14]
                uart_dm_drive <= din_s[0]; // [RULE10]
                uart_dm_drive_en <= carkit_r[`UAMC_CK_OUT_ROUTE]; // [RULE10]
                uart_pullup_en <= 1'b1; // [RULE11]
                regulator_level <= pwr_r[1:0]; // [RULE11]
            end else if (in_alt && headset_r[`UAMC_HS_EN]) begin
                // headset: outputs on 0,1,3,4,5; inputs on 2,6,7
                link_data_oe <= 8'h3b; // [RULE18]
                link_data_out <= {2'b00, idopen_s, idlow_s, 1'b0, 1'b0,
                                  vbus_s & ckirq_r[`UAMC_CKIRQ_VBUS], sess_s}; // [RULE19] [RULE20] [RULE21]
                id_pin_ground_drive <= din_s[2]; // [RULE22]
                id_weak_pullup_en <= din_s[6]; // [RULE22]
                id_strong_pullup_en <= din_s[7]; // [RULE22]
            end else if (state_r == ST_SYNC) begin
                // synchronous mode events as receive commands
                if (id_fall) begin
                    rxcmd_valid <= 1'b1;
                    rxcmd_data <= 8'h00; // [RULE14]
                end else if (id_meas_done && rid_r[`UAMC_RID_START] && rid_r[`UAMC_RID_IRQ_EN]) begin
                    rxcmd_valid <= 1'b1;
                    rxcmd_data <= {1'b1, idlow_s, 6'h00}; // [RULE16]
                end
            end
        end
    end
endmodule // uamc_alt_mode
`default_nettype wire

// ===== uamc_alt_mode_monitor.sv
// concurrent checks on the alternate mode control ports
`timescale 1ns/1ns
`default_nettype none
module uamc_alt_mode_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic hw_reset_n,
    input wire logic link_stp,
    input wire logic [7:0] link_data_out,
    input wire logic [7:0] link_data_oe,
    input wire logic link_dir,
    input wire logic uart_dm_drive_en,
    input wire logic uart_pullup_en,
    input wire logic id_meas_start_pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic wr_taken; // write address phase accepted
    logic mode_wr_r; // data phase of a mode select write
    logic rid_wr_r; // data phase of a conversion register write
    logic start_r; // start bit was written
    logic [3:0] since_wr_r; // cycles since mode select write
    logic [3:0] since_stp_r; // cycles since stop or pin reset
    assign wr_taken = hsel && htrans[1] && hready && hwrite;
    // track mode select and conversion writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_wr_r <= 1'b0;
            rid_wr_r <= 1'b0;
            start_r <= 1'b0;
            since_wr_r <= 4'hf;
            since_stp_r <= 4'hf;
        end else begin
            mode_wr_r <= wr_taken && (haddr[7:2] == 6'h07 || haddr[7:2] == 6'h08 || haddr[7:2] == 6'h33);
            rid_wr_r <= wr_taken && (haddr[7:2] == 6'h36 || haddr[7:2] == 6'h37);
            start_r <= rid_wr_r && hwdata[0];
            since_wr_r <= mode_wr_r ? 4'h0 : since_wr_r + {3'b0, since_wr_r != 4'hf};
            since_stp_r <= (link_stp || !hw_reset_n) ? 4'h0 : since_stp_r + {3'b0, since_stp_r != 4'hf};
        end
    end
    // stop while the device owns the bus
    sequence alt_stop_s;
        link_dir && link_stp ##1 link_dir && link_stp;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready okay");
    AST_ENTRY_DELAY: assert property ($rose(link_dir) |-> since_wr_r >= 4'd5)
        else $error("dir rose too soon after mode write");
    AST_STP_EXIT: assert property (alt_stop_s |-> ##[0:8] !link_dir)
        else $error("dir not dropped after stop");
    AST_EXIT_CAUSE: assert property ($fell(link_dir) |-> since_stp_r <= 4'd6)
        else $error("dir dropped without stop or pin reset");
    AST_PIN_RESET: assert property ($fell(hw_reset_n) |-> ##[1:6] !link_dir)
        else $error("pin reset left alternate mode on");
    AST_BIT7_LOW: assert property (link_dir |-> !(link_data_oe[7] && link_data_out[7]))
        else $error("bus bit 7 driven high");
    AST_UART_TX: assert property (uart_dm_drive_en |-> link_dir && !link_data_oe[0])
        else $error("uart route outside carkit mode");
    AST_CARKIT_LOW: assert property (link_dir && uart_pullup_en |-> (link_data_out & link_data_oe & 8'hf4) == 8'h00)
        else $error("reserved carkit bits driven high");
    AST_START: assert property (id_meas_start_pulse |-> start_r || $past(start_r))
        else $error("start pulse without start write");
endmodule // uamc_alt_mode_chk
`default_nettype wire

// ===== uamc_consts.vh
// constants for the ulpi alternate mode control block
`ifndef UAMC_CONSTS_VH
`define UAMC_CONSTS_VH
// register indices; byte address is four times the index
`define UAMC_IDX_FUNC 6'h04
`define UAMC_IDX_IFC 6'h07
`define UAMC_IDX_CARKIT 6'h19
`define UAMC_IDX_CKIRQ 6'h1d
`define UAMC_IDX_HEADSET 6'h33
`define UAMC_IDX_RID 6'h36
`define UAMC_IDX_PWR 6'h39
`define UAMC_IDX_STATUS 6'h3c
// reset values
`define UAMC_RST_FUNC 8'h41
`define UAMC_RST_PWR 8'h04
// interface control fields
`define UAMC_IFC_SERIAL 0
`define UAMC_IFC_CARKIT 2
`define UAMC_IFC_KEEPCLK 3
// carkit control fields
`define UAMC_CK_OUT_ROUTE 0
`define UAMC_CK_IN_ROUTE 1
`define UAMC_CK_LEFT 2
`define UAMC_CK_RIGHT 3
// headset audio mode field
`define UAMC_HS_EN 0
// id conversion register fields
`define UAMC_RID_START 0
`define UAMC_RID_IRQ_EN 1
`define UAMC_RID_RES_LSB 3
// carkit irq enable bit feeding the vbus valid output
`define UAMC_CKIRQ_VBUS 1
// receive command bits
`define UAMC_RXCMD_ID 6
`define UAMC_RXCMD_ALT 7
// mode entry delay
`define UAMC_ENTRY_CYCLES 3'd5
`endif

// ===== uamc_link_model.sv
// link controller model on the far side of the data bus
`timescale 1ns/1ns
`default_nettype none
module uamc_link_model (
    output logic link_stp,
    output logic [7:0] link_drv,
    input wire logic link_dir
);
    logic lclk = 1'b0; // link clock, 160 ns, own phase
    logic [7:0] pend = 8'h00; // next value for the bus
    // link clock generator
    initial begin
        link_stp = 1'b0;
        #7;
        forever #80 lclk = ~lclk;
    end
    // bus bits change only on the link clock
    always @(posedge lclk) link_drv <= pend;
    // present a value and let it settle two link edges
    task put(input logic [7:0] v);
        pend = v;
        repeat (2) @(posedge lclk);
    endtask
    // raise stop, hold until dir drops, then release it
    task leave;
        @(posedge lclk);
        link_stp <= 1'b1;
        for (int i = 0; i < 20 && link_dir !== 1'b0; i++) @(posedge lclk);
        @(posedge lclk);
        link_stp <= 1'b0;
        pend = 8'h00;
    endtask
endmodule // uamc_link_model
`default_nettype wire

// ===== uamc_tb.sv
// self-checking bench for the alternate mode control block
`timescale 1ns/1ns
`default_nettype none
`include "uamc_consts.vh"
module testbench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hw_reset_n = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'b00, regulator_level, edge_rate_sel;
    logic [2:0] hsize = 3'b010;
    logic serial_rx_plus_line = 1'b0, serial_rx_minus_line = 1'b0, serial_rx_diff = 1'b0;
    logic id_low_comparator = 1'b1, session_valid_cmp = 1'b0, vbus_valid_cmp = 1'b0;
    logic id_pin_open_state = 1'b0, id_meas_done = 1'b0, saw_start = 1'b0;
    logic [4:0] id_meas_code = 5'h00;
    logic [7:0] irq_src = 8'h00, link_drv, link_data_out, link_data_oe, rxcmd_data, rx_last = 8'h00;
    logic hreadyout, hresp, link_stp, link_dir, clk_run, rxcmd_valid, tx_enable_out, tx_diff_out;
    logic serial_tx_single_zero, uart_dm_drive, uart_dm_drive_en, uart_pullup_en, id_meas_start_pulse;
    logic left_audio_switch_en, right_audio_switch_en, id_pin_ground_drive, id_weak_pullup_en, id_strong_pullup_en;
    wire logic hready; // single slave
    wire logic [7:0] link_data_in; // resolved bus
    int failures = 0, num_checks = 0;
    assign hready = hreadyout;
    assign link_data_in = (link_data_oe & link_data_out) | (~link_data_oe & link_drv);
    uamc_alt_mode dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .hw_reset_n, .link_stp, .link_data_in, .link_data_out, .link_data_oe,
        .link_dir, .clk_run, .rxcmd_valid, .rxcmd_data, .serial_rx_plus_line, .serial_rx_minus_line,
        .serial_rx_diff, .irq_src, .id_low_comparator, .session_valid_cmp, .vbus_valid_cmp,
        .id_pin_open_state, .id_meas_done, .id_meas_code, .tx_enable_out, .tx_diff_out,
        .serial_tx_single_zero, .uart_dm_drive, .uart_dm_drive_en, .uart_pullup_en, .regulator_level,
        .edge_rate_sel, .left_audio_switch_en, .right_audio_switch_en, .id_pin_ground_drive,
        .id_weak_pullup_en, .id_strong_pullup_en, .id_meas_start_pulse);
    uamc_link_model link (.link_stp, .link_drv, .link_dir);
    // block clock, 20 ns
    always #10 hclk = ~hclk;
    // catch one-cycle pulses
    always @(posedge hclk) begin
        if (id_meas_start_pulse === 1'b1) saw_start <= 1'b1;
        if (rxcmd_valid === 1'b1) rx_last <= rxcmd_data;
    end
    // compare one byte
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one single-word transfer
    task ahb(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task wr(input logic [5:0] idx, input logic [7:0] v);
        logic [7:0] d;
        ahb(1'b1, idx, v, d);
    endtask
    task rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] d;
        ahb(1'b0, idx, 8'h00, d);
        chk(d, exp, what);
    endtask
    // bounded wait for dir
    task wait_dir(input logic v, input string what);
        for (int i = 0; i < 60 && link_dir !== v; i++) @(posedge hclk);
        chk({7'h0, link_dir}, {7'h0, v}, what);
    endtask
    task t_regs;
        rd_chk(`UAMC_IDX_FUNC, `UAMC_RST_FUNC, "func rst");
        rd_chk(`UAMC_IDX_PWR, `UAMC_RST_PWR, "pwr rst");
        rd_chk(`UAMC_IDX_IFC, 8'h00, "ifc rst");
        rd_chk(6'h30, 8'h00, "unmapped");
    endtask
    task t_serial;
        wr(`UAMC_IDX_IFC, 8'h01);
        wait_dir(1'b1, "serial dir");
        repeat (2) @(posedge hclk);
        chk({7'h0, clk_run}, 8'h00, "serial clk");
        chk(link_data_oe & 8'hf8, 8'hf8, "serial oe");
        link.put(8'h03);
        chk({5'h0, tx_enable_out, tx_diff_out, serial_tx_single_zero}, 8'h06, "serial tx");
        link.put(8'h04);
        chk({7'h0, tx_enable_out}, 8'h00, "serial tx off");
        @(posedge hclk);
        serial_rx_plus_line <= 1'b1;
        serial_rx_diff <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(link_data_out & 8'hf0, 8'h50, "serial rx");
        link.leave;
        wait_dir(1'b0, "serial exit");
        repeat (6) @(posedge hclk);
        rd_chk(`UAMC_IDX_IFC, 8'h00, "serial clr");
    endtask
    task t_carkit;
        wr(`UAMC_IDX_PWR, 8'h06);
        wr(`UAMC_IDX_CKIRQ, 8'hff);
        wr(`UAMC_IDX_CARKIT, 8'h0f);
        repeat (2) @(posedge hclk);
        chk({6'h0, left_audio_switch_en, right_audio_switch_en}, 8'h03, "audio");
        wr(`UAMC_IDX_IFC, 8'h0c);
        wait_dir(1'b1, "carkit dir");
        repeat (2) @(posedge hclk);
        chk({4'h0, clk_run, uart_pullup_en, regulator_level}, 8'h0e, "uart entry");
        chk({6'h0, edge_rate_sel}, 8'h01, "edge rate");
        link.put(8'h01);
        chk({6'h0, uart_dm_drive_en, uart_dm_drive}, 8'h03, "uart tx");
        chk(link_data_out & 8'hf6, 8'h02, "uart rx");
        @(posedge hclk);
        irq_src <= 8'h01;
        repeat (6) @(posedge hclk);
        chk({7'h0, link_data_out[3]}, 8'h01, "carkit irq");
        hw_reset_n <= 1'b0;
        repeat (5) @(posedge hclk);
        hw_reset_n <= 1'b1;
        irq_src <= 8'h00;
        wait_dir(1'b0, "pin rst exit");
        repeat (4) @(posedge hclk);
        rd_chk(`UAMC_IDX_IFC, 8'h00, "carkit clr");
    endtask
    task t_headset;
        wr(`UAMC_IDX_CKIRQ, 8'h02);
        session_valid_cmp <= 1'b1;
        vbus_valid_cmp <= 1'b1;
        id_pin_open_state <= 1'b1;
        wr(`UAMC_IDX_HEADSET, 8'h01);
        wait_dir(1'b1, "headset dir");
        link.put(8'hc4);
        chk(link_data_out & 8'h3b, 8'h33, "headset out");
        chk({5'h0, id_pin_ground_drive, id_weak_pullup_en, id_strong_pullup_en}, 8'h07, "id drive");
        link.leave;
        wait_dir(1'b0, "headset exit");
        repeat (6) @(posedge hclk);
        rd_chk(`UAMC_IDX_HEADSET, 8'h00, "headset clr");
    endtask
    task t_rid;
        wr(`UAMC_IDX_RID, 8'h03);
        repeat (2) @(posedge hclk);
        chk({7'h0, saw_start}, 8'h01, "start");
        rd_chk(`UAMC_IDX_RID, 8'h03, "busy");
        id_meas_code <= 5'h15;
        id_meas_done <= 1'b1;
        @(posedge hclk);
        id_meas_done <= 1'b0;
        repeat (4) @(posedge hclk);
        chk({7'h0, rx_last[`UAMC_RXCMD_ALT]}, 8'h01, "alt irq");
        rd_chk(`UAMC_IDX_RID, 8'haa, "result");
        id_low_comparator <= 1'b0;
        repeat (6) @(posedge hclk);
        chk({7'h0, rx_last[`UAMC_RXCMD_ID]}, 8'h00, "id gnd");
    endtask
    task report_and_stop;
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_regs;
        t_serial;
        t_carkit;
        t_headset;
        t_rid;
        report_and_stop;
    end
    // watchdog
    initial begin
        #200000;
        failures++;
        report_and_stop;
    end
endmodule // testbench
bind uamc_alt_mode uamc_alt_mode_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hw_reset_n, .link_stp, .link_data_out, .link_data_oe, .link_dir,
    .uart_dm_drive_en, .uart_pullup_en, .id_meas_start_pulse);
`default_nettype wire
